// *** logic/lco_top.sv ***
// calibration timing, open-loop configuration registers and fallback control
`timescale 1ns/100ps
// Overview of operation
// - Codes 0, 1 and 2 of the calibration length field run calibration for 250, 500 and 1000 ms, code 2 after reset.
// - Code 3 keeps calibration running until the external trigger, the enable or the software trigger ends it.
// - After the ending trigger the block takes its measurements for a few ms before calibration counts as done.
// - With the fallback enable bit 7 set, repeated zero-cross failures switch the drive to open loop.
// - Open loop entered by fallback always uses a square wave, whatever the waveform select bit says.
// - Bits 6-5 set the attempts before fallback: codes 0 to 3 give 3, 4, 5 and 6 attempts.
// - In open loop bit 0 selects the waveform, 0 square and 1 sine, square after reset.
// - The open-loop period is the 10-bit period value times 24.615 ns, 198 after reset.
// - During calibration the overdrive time clamp is ignored and automatic overdrive is used.
module lco_top
#(
  parameter int unsigned CAL0_CYC = lco_pkg::CAL_250_CYC,
  parameter int unsigned CAL1_CYC = lco_pkg::CAL_500_CYC,
  parameter int unsigned CAL2_CYC = lco_pkg::CAL_1000_CYC,
  parameter int unsigned MEAS_CYC = lco_pkg::MEAS_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // calibration control
  input wire logic cal_start_i,
  input wire logic ext_trig_i,
  input wire logic sw_trig_i,
  input wire logic en_trig_i,
  output logic cal_active_o,
  output logic cal_measure_o,
  output logic cal_done_o,
  // overdrive
  input wire logic [1:0] overdrive_time_clamp_i,
  output logic [1:0] overdrive_time_clamp_o,
  // drive generator
  input wire logic open_loop_req_i,
  input wire logic zero_cross_detect_i,
  input wire logic zero_cross_miss_i,
  input wire logic drive_stop_i,
  output logic open_loop_o,
  output logic sine_o,
  output logic [9:0] fallback_drive_period_o,
  output logic fallback_enabled_flag_o,
  output logic [2:0] fallback_attempt_count_o
);
  import lco_pkg::*;

  typedef struct packed {
    lco_cal_st_t st;
    logic [27:0] cnt;
    logic [7:0] cal_len;
    logic [7:0] fb_cfg;
    logic [7:0] per_hi;
    logic [7:0] per_lo;
    logic [7:0] rdata;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic active;
    logic meas;
    logic done;
    logic [1:0] od;
    logic open_loop;
    logic sine;
    logic [9:0] period;
  } lco_state_t;

  localparam lco_state_t RST = '{
    st: LCO_IDLE, cnt: 28'h0, cal_len: CAL_LEN_RST, fb_cfg: FB_CFG_RST,
    per_hi: PER_HI_RST, per_lo: PER_LO_RST, rdata: 8'h00, trig_sync: 2'h0,
    trig_prev: 1'b0, active: 1'b0, meas: 1'b0, done: 1'b0, od: 2'h0,
    open_loop: 1'b0, sine: 1'b0, period: {PER_HI_RST[1:0], PER_LO_RST}};

  lco_state_t s_q;
  lco_state_t s_d;
  logic [1:0] len_code;
  logic [27:0] cal_lim;
  logic end_trig;
  logic fb_flag;

  assign len_code = s_q.cal_len[CAL_LEN_LSB +: 2];

  // fixed calibration length from the code; code 3 never reaches this limit
  always_comb
  begin
    unique case (len_code)
      CAL_CODE_250: cal_lim = CAL0_CYC[27:0];
      CAL_CODE_500: cal_lim = CAL1_CYC[27:0];
      default: cal_lim = CAL2_CYC[27:0];
    endcase
  end

  // any of the three triggers ends a trigger-bounded run; the pin is synchronised first
  assign end_trig = (s_q.trig_sync[1] && !s_q.trig_prev) || sw_trig_i || en_trig_i;

  // zero-cross failure tracking lives in its own module
  lco_fallback u_fallback
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .fallback_enable_i(s_q.fb_cfg[FB_EN_BIT]),
    .fallback_attempt_limit_i(s_q.fb_cfg[FB_CNT_LSB +: 2]),
    .zero_cross_detect_i(zero_cross_detect_i),
    .zero_cross_miss_i(zero_cross_miss_i),
    .drive_stop_i(drive_stop_i),
    .fallback_enabled_flag_o(fb_flag),
    .fallback_attempt_count_o(fallback_attempt_count_o)
  );

  // next state: register port, calibration sequencer, drive selection
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.trig_sync = {s_q.trig_sync[0], ext_trig_i};
    s_d.trig_prev = s_q.trig_sync[1];

    // whole bytes are stored, reserved bits included, so they read back
    if (reg_we_i)
    begin
      unique case (reg_addr_i)
        CAL_LEN_OFS: s_d.cal_len = reg_wdata_i;
        FB_CFG_OFS: s_d.fb_cfg = reg_wdata_i;
        PER_HI_OFS: s_d.per_hi = reg_wdata_i;
        PER_LO_OFS: s_d.per_lo = reg_wdata_i;
        default: ;
      endcase
    end

    // read data is held until the next read; unmapped offsets read zero
    if (reg_re_i)
    begin
      unique case (reg_addr_i)
        CAL_LEN_OFS: s_d.rdata = s_q.cal_len;
        FB_CFG_OFS: s_d.rdata = s_q.fb_cfg;
        PER_HI_OFS: s_d.rdata = s_q.per_hi;
        PER_LO_OFS: s_d.rdata = s_q.per_lo;
        default: s_d.rdata = 8'h00;
      endcase
    end

    // calibration sequencer; a new start during a run is ignored
    unique case (s_q.st)
      LCO_IDLE:
      begin
        if (cal_start_i)
        begin
          s_d.st = LCO_RUN;
          s_d.cnt = 28'h0;
        end
      end
      LCO_RUN:
      begin
        // no minimum is enforced in trigger mode: an early trigger is obeyed
        if ((len_code != CAL_CODE_TRIG && s_q.cnt == cal_lim - 28'h1)
            || (len_code == CAL_CODE_TRIG && end_trig))
        begin
          s_d.st = LCO_MEAS;
          s_d.cnt = 28'h0;
        end
        else if (s_q.cnt != 28'hfffffff)
        begin
          s_d.cnt = s_q.cnt + 28'h1;
        end
      end
      LCO_MEAS:
      begin
        if (s_q.cnt == MEAS_CYC[27:0] - 28'h1)
        begin
          s_d.st = LCO_IDLE;
          s_d.done = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 28'h1;
        end
      end
      default:
      begin
        s_d.st = LCO_IDLE;
        s_d.cnt = 28'h0;
      end
    endcase

    s_d.active = (s_d.st != LCO_IDLE);
    s_d.meas = (s_d.st == LCO_MEAS);
    // calibration forces automatic overdrive, which is clamp code zero
    s_d.od = s_d.active ? 2'h0 : overdrive_time_clamp_i;

    // fallback beats the waveform select: it is always square
    s_d.open_loop = open_loop_req_i || fb_flag;
    s_d.sine = open_loop_req_i && !fb_flag && s_q.fb_cfg[WAVE_SEL_BIT];
    // period in steps of the open-loop step; only bits 1-0 of the high byte count
    s_d.period = {s_d.per_hi[PER_HI_LSB +: 2], s_d.per_lo};
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= RST;
    else
      s_q <= s_d;
  end

  assign reg_rdata_o = s_q.rdata;
  assign cal_active_o = s_q.active;
  assign cal_measure_o = s_q.meas;
  assign cal_done_o = s_q.done;
  assign overdrive_time_clamp_o = s_q.od;
  assign open_loop_o = s_q.open_loop;
  assign sine_o = s_q.sine;
  assign fallback_drive_period_o = s_q.period;
  assign fallback_enabled_flag_o = fb_flag;

  a_fixed_len_end: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (s_q.st == LCO_RUN && len_code != CAL_CODE_TRIG && s_q.cnt == cal_lim - 28'h1)
    |=> (s_q.st == LCO_MEAS && cal_measure_o))
    else $error("fixed calibration did not end at its length");

  a_trig_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (s_q.st == LCO_RUN && len_code == CAL_CODE_TRIG && !end_trig)
    |=> (s_q.st == LCO_RUN && !cal_done_o))
    else $error("trigger-bounded calibration ended without a trigger");

  a_meas_before_done: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(cal_done_o) |-> $past(cal_measure_o) && !cal_active_o)
    else $error("calibration done without a measurement phase");

  a_od_forced_auto: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cal_active_o |-> overdrive_time_clamp_o == 2'h0)
    else $error("overdrive clamp applied during calibration");

  a_square_fallback: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $past(fb_flag) |-> (!sine_o && open_loop_o))
    else $error("fallback open loop not square");

  a_sine_select: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ($past(open_loop_req_i) && !$past(fb_flag)) |-> sine_o == $past(s_q.fb_cfg[0]))
    else $error("open-loop waveform does not follow select bit");

  a_period_join: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (reg_we_i && reg_addr_i == PER_LO_OFS)
    |=> fallback_drive_period_o == {s_q.per_hi[1:0], $past(reg_wdata_i)})
    else $error("open-loop period not formed from both registers");

  a_reserved_keep: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (reg_we_i && reg_addr_i == FB_CFG_OFS) ##1 (reg_re_i && reg_addr_i == FB_CFG_OFS
    && !reg_we_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("written byte did not read back whole");

  c_fixed_cal: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cal_done_o && len_code != CAL_CODE_TRIG);
  c_trig_cal: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(cal_measure_o) && len_code == CAL_CODE_TRIG);
  c_sine_drive: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    open_loop_o && sine_o);

endmodule : lco_top

// *** logic/lco_pkg.sv ***
// shared constants and types for the calibration timing and open-loop fallback block
package lco_pkg;

  // clock rate
  localparam int unsigned CLK_HZ = 200_000_000;

  // register offsets
  localparam logic [7:0] CAL_LEN_OFS = 8'h2a;
  localparam logic [7:0] FB_CFG_OFS = 8'h2c;
  localparam logic [7:0] PER_HI_OFS = 8'h2e;
  localparam logic [7:0] PER_LO_OFS = 8'h2f;

  // values after reset
  localparam logic [7:0] CAL_LEN_RST = 8'h02;
  localparam logic [7:0] FB_CFG_RST = 8'h00;
  localparam logic [7:0] PER_HI_RST = 8'h00;
  localparam logic [7:0] PER_LO_RST = 8'hc6;

  // field positions
  localparam int unsigned CAL_LEN_LSB = 0;
  localparam int unsigned FB_EN_BIT = 7;
  localparam int unsigned FB_CNT_LSB = 5;
  localparam int unsigned WAVE_SEL_BIT = 0;
  localparam int unsigned PER_HI_LSB = 0;

  // calibration length codes
  localparam logic [1:0] CAL_CODE_250 = 2'h0;
  localparam logic [1:0] CAL_CODE_500 = 2'h1;
  localparam logic [1:0] CAL_CODE_TRIG = 2'h3;

  // calibration times and their cycle counts
  localparam int unsigned CAL_250_MS = 250;
  localparam int unsigned CAL_500_MS = 500;
  localparam int unsigned CAL_1000_MS = 1000;
  localparam int unsigned CAL_250_CYC = CAL_250_MS * (CLK_HZ / 1000);
  localparam int unsigned CAL_500_CYC = CAL_500_MS * (CLK_HZ / 1000);
  localparam int unsigned CAL_1000_CYC = CAL_1000_MS * (CLK_HZ / 1000);
  // closing measurement window after the end of calibration
  localparam int unsigned MEAS_TIME_US = 5000;
  localparam int unsigned MEAS_CYC = MEAS_TIME_US * (CLK_HZ / 1_000_000);

  // fallback attempts: code 0 means this many, each code step adds one
  localparam logic [2:0] FB_ATTEMPT_BASE = 3'h3;

  // open-loop period step, in picoseconds, and the same step in cycles
  localparam int unsigned OL_STEP_PS = 24615;
  localparam int unsigned CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int unsigned OL_STEP_CYC = OL_STEP_PS / CLK_PERIOD_PS;

  // calibration sequencer states
  typedef enum logic [1:0] {
    LCO_IDLE = 2'b00,
    LCO_RUN = 2'b01,
    LCO_MEAS = 2'b10
  } lco_cal_st_t;

endpackage : lco_pkg

// *** logic/lco_fallback.sv ***
// zero-cross failure tracker that forces the drive into open loop
`timescale 1ns/100ps
module lco_fallback
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // configuration
  input wire logic fallback_enable_i,
  input wire logic [1:0] fallback_attempt_limit_i,
  // zero-cross events from the drive
  input wire logic zero_cross_detect_i,
  input wire logic zero_cross_miss_i,
  input wire logic drive_stop_i,
  // result
  output logic fallback_enabled_flag_o,
  output logic [2:0] fallback_attempt_count_o
);
  import lco_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic flag;
  } lco_fb_state_t;

  lco_fb_state_t s_q;
  lco_fb_state_t s_d;
  logic [2:0] lim;

  // attempt limit runs from three to six
  assign lim = FB_ATTEMPT_BASE + {1'b0, fallback_attempt_limit_i};

  // count consecutive misses; a good detection restarts the count
  always_comb
  begin
    s_d = s_q;
    if (!fallback_enable_i)
    begin
      s_d.cnt = 3'h0;
      s_d.flag = 1'b0;
    end
    // the miss that reaches the limit beats a drive stop in the same cycle
    else if (!s_q.flag && zero_cross_miss_i && (s_q.cnt + 3'h1 >= lim))
    begin
      s_d.flag = 1'b1;
      s_d.cnt = 3'h0;
    end
    else if (drive_stop_i)
    begin
      s_d.cnt = 3'h0;
      s_d.flag = 1'b0;
    end
    else if (s_q.flag)
    begin
      s_d.cnt = 3'h0;
    end
    else if (zero_cross_miss_i)
    begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
    else if (zero_cross_detect_i)
    begin
      s_d.cnt = 3'h0;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign fallback_enabled_flag_o = s_q.flag;
  assign fallback_attempt_count_o = s_q.cnt;

  a_fb_disabled: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !fallback_enable_i |=> !fallback_enabled_flag_o)
    else $error("fallback flag set while fallback disabled");

  a_fb_limit_hit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (fallback_enable_i && !s_q.flag && zero_cross_miss_i
     && s_q.cnt == lim - 3'h1) |=> fallback_enabled_flag_o)
    else $error("fallback not entered at the attempt limit");

  a_fb_no_early: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(fallback_enabled_flag_o) |-> $past(s_q.cnt) == $past(lim) - 3'h1)
    else $error("fallback entered before the attempt limit");

  c_fb_entered: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(fallback_enabled_flag_o));

endmodule : lco_fallback

// *** testbench/lco_act_model.sv ***
// behavioural actuator giving one zero-cross verdict per drive half-cycle
`timescale 1ns/100ps
module lco_act_model
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // bench control
  input wire logic healthy_i,
  // verdicts seen by the drive
  output logic zero_cross_detect_o,
  output logic zero_cross_miss_o
);
  logic [1:0] phase_q;
  // a verdict every fourth cycle, never two in adjacent cycles
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phase_q <= 2'h0;
      zero_cross_detect_o <= 1'b0;
      zero_cross_miss_o <= 1'b0;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      zero_cross_detect_o <= (phase_q == 2'h3) && healthy_i;
      zero_cross_miss_o <= (phase_q == 2'h3) && !healthy_i;
    end
  end
endmodule : lco_act_model

// *** testbench/tb.sv ***
// self-checking bench for calibration timing and open-loop fallback
`timescale 1ns/100ps
module tb;
  import lco_pkg::*;
  // short counts keep the run brief
  localparam int unsigned C0 = 20;
  localparam int unsigned C1 = 40;
  localparam int unsigned C2 = 80;
  localparam int unsigned CM = 10;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic start = 1'b0;
  logic ext_trig = 1'b0;
  logic sw_trig = 1'b0;
  logic en_trig = 1'b0;
  logic ol_req = 1'b0;
  logic stop = 1'b0;
  logic healthy = 1'b1;
  logic [7:0] rdata;
  logic active, measure, done, ol, sine, flag, zc_det, zc_miss;
  logic [1:0] od_clamp;
  logic [9:0] period;
  logic [2:0] att_cnt;
  int fails = 0;
  int n_compared = 0;
  int n;
  int unsigned cyc[3] = '{C0, C1, C2};

  lco_top #(.CAL0_CYC(C0), .CAL1_CYC(C1), .CAL2_CYC(C2), .MEAS_CYC(CM)) lco_top_inst
  (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .cal_start_i(start),
    .ext_trig_i(ext_trig), .sw_trig_i(sw_trig), .en_trig_i(en_trig),
    .cal_active_o(active), .cal_measure_o(measure), .cal_done_o(done),
    .overdrive_time_clamp_i(2'h3), .overdrive_time_clamp_o(od_clamp),
    .open_loop_req_i(ol_req), .zero_cross_detect_i(zc_det), .zero_cross_miss_i(zc_miss),
    .drive_stop_i(stop), .open_loop_o(ol), .sine_o(sine), .fallback_drive_period_o(period),
    .fallback_enabled_flag_o(flag), .fallback_attempt_count_o(att_cnt)
  );
  lco_act_model lco_act_model_inst
  (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .healthy_i(healthy),
    .zero_cross_detect_o(zc_det), .zero_cross_miss_o(zc_miss)
  );

  // 200 MHz clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one-cycle strobes, launched and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge sys_clk_i);
    we = 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_i);
    addr = a;
    re = 1'b1;
    @(negedge sys_clk_i);
    re = 1'b0;
    chk("rdata", {2'h0, e}, {2'h0, rdata});
  endtask : rchk

  // write, then read the same offset in the very next cycle
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge sys_clk_i);
    we = 1'b0;
    re = 1'b1;
    @(negedge sys_clk_i);
    re = 1'b0;
    chk("rdata_b2b", {2'h0, d}, {2'h0, rdata});
  endtask : wrrd

  // k: 0 software, 1 enable, 2 pin, 3 start, else drive stop
  task automatic pulse(input int k);
    @(negedge sys_clk_i);
    case (k)
      0: sw_trig = 1'b1;
      1: en_trig = 1'b1;
      2: ext_trig = 1'b1;
      3: start = 1'b1;
      default: stop = 1'b1;
    endcase
    @(negedge sys_clk_i);
    {sw_trig, en_trig, ext_trig, start, stop} = 5'h00;
  endtask : pulse

  // falling edges until measure (w=0) or done (w=1), bounded
  task automatic cnt_until(input int w, output int c);
    c = 0;
    while (((w == 0) ? measure : done) !== 1'b1 && c < 1000)
    begin
      sw_trig = (w == 0 && c == 3);
      @(negedge sys_clk_i);
      c++;
    end
  endtask : cnt_until

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // watchdog, well past the several hundred cycles the tests need
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    rchk(CAL_LEN_OFS, 8'h02);
    rchk(FB_CFG_OFS, 8'h00);
    rchk(PER_HI_OFS, 8'h00);
    rchk(PER_LO_OFS, 8'hc6);
    chk("period", 10'd198, period);
    rchk(8'h2d, 8'h00);
    // fixed lengths with reserved bits set; a stray trigger must not cut the run
    for (int c = 0; c < 3; c++)
    begin
      wr(CAL_LEN_OFS, 8'hfc | 8'(c));
      pulse(3);
      chk("active", 10'h1, {9'h0, active});
      cnt_until(0, n);
      chk("run_len", 10'(cyc[c]), 10'(n));
      chk("od_clamp", 10'h0, {8'h0, od_clamp});
      cnt_until(1, n);
      chk("meas_len", 10'(CM), 10'(n));
    end
    chk("od_idle", 10'h3, {8'h0, od_clamp});
    // trigger-bounded runs held past the longest fixed length
    wr(CAL_LEN_OFS, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      pulse(3);
      repeat (C2 + 5) @(negedge sys_clk_i);
      chk("held", 10'h0, {9'h0, measure});
      pulse(k);
      n = 0;
      while (measure !== 1'b1 && n < 8)
      begin
        @(negedge sys_clk_i);
        n++;
      end
      chk("trig_end", 10'h1, {9'h0, n <= ((k == 2) ? 4 : 1)});
      cnt_until(1, n);
      chk("meas_trig", 10'(CM), 10'(n));
    end
    // fallback after 3 to 6 misses, square even with sine selected
    for (int c = 0; c < 4; c++)
    begin
      wr(FB_CFG_OFS, 8'h81 | 8'(c << 5));
      healthy = 1'b0;
      n = 0;
      for (int m = 0; m < 200 && flag !== 1'b1; m++)
      begin
        @(negedge sys_clk_i);
        if (flag !== 1'b1 && zc_miss === 1'b1)
        begin
          n++;
          // misses already taken are those before the one now on the pin
          chk("att_cnt", 10'(n - 1), {7'h0, att_cnt});
        end
      end
      chk("misses", 10'(3 + c), 10'(n));
      @(negedge sys_clk_i);
      chk("ol_fb", 10'h1, {9'h0, ol});
      // a software request with sine selected must still give square
      ol_req = 1'b1;
      @(negedge sys_clk_i);
      chk("sine_fb", 10'h0, {9'h0, sine});
      ol_req = 1'b0;
      healthy = 1'b1;
      pulse(4);
      chk("flag_clr", 10'h0, {9'h0, flag});
    end
    // disabled fallback ignores misses
    wr(FB_CFG_OFS, 8'h61);
    healthy = 1'b0;
    repeat (40) @(negedge sys_clk_i);
    chk("flag_off", 10'h0, {9'h0, flag});
    chk("att_off", 10'h0, {7'h0, att_cnt});
    healthy = 1'b1;
    ol_req = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk("sine_req", 10'h1, {9'h0, sine});
    wr(FB_CFG_OFS, 8'h60);
    @(negedge sys_clk_i);
    chk("square_req", 10'h0, {9'h0, sine});
    ol_req = 1'b0;
    wr(PER_HI_OFS, 8'hff);
    wr(PER_LO_OFS, 8'h01);
    @(negedge sys_clk_i);
    chk("period", 10'h301, period);
    rchk(PER_HI_OFS, 8'hff);
    wrrd(FB_CFG_OFS, 8'h1e);
    stop_test();
  end
endmodule : tb
